/* File: core/led_reset_enable_ctrl.sv */
// LED driver output enable, resets, bus reset call and brightness waveforms
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_reset_enable_ctrl #(
	parameter int POR_WAKE_CYC = `POR_WAKE_CYC,
	parameter int PIN_REC_CYC = `PIN_REC_CYC,
	parameter int SW_REC_CYC = `SW_REC_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Device pins
	input wire logic oe_n_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// LED outputs
	output logic [`NUM_LED-1:0] led_o,
	output logic [`NUM_LED-1:0] led_oe_o,
	output logic ready_o
);
	import led_ctrl_pkg::*;

	st_t state_q;
	st_t state_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[8*b+:8] = nw[8*b+:8];
			end
		end
		return r;
	endfunction

	// Brightness block: second quarter of the map, one word per channel
	function automatic logic is_bright(input logic [7:0] a);
		return a[7:6] == 2'(`ADR_BRIGHT >> 6);
	endfunction

	// Back to power-up values for configuration and serial logic
	function automatic st_t clear_cfg(input st_t s);
		st_t r;
		r = s;
		r.blink_sel = 1'b0;
		r.drive = '0;
		r.gduty = 8'h00;
		r.gfreq = 8'h00;
		r.bright = '0;
		r.i2c = I2C_IDLE;
		r.bitcnt = 4'h0;
		r.shreg = 8'h00;
		r.first = 1'b0;
		r.armed = 1'b0;
		r.sda_oe = 1'b0;
		return r;
	endfunction

	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic busy;
		logic step;
		logic wrap;
		logic ind;
		logic grp;
		logic req;
		logic [10:0] glim;
		logic [31:0] rd;
		logic [31:0] wr;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		busy = 1'b0;
		step = 1'b0;
		wrap = 1'b0;
		ind = 1'b0;
		grp = 1'b0;
		req = 1'b0;
		glim = 11'h000;
		rd = 32'h0000_0000;
		wr = 32'h0000_0000;
		state_d = state_q;

		// Two-stage synchronisers; edges are taken from the second stage only
		state_d.scl_s1 = scl_i;
		state_d.scl_s2 = state_q.scl_s1;
		state_d.scl_p = state_q.scl_s2;
		state_d.sda_s1 = sda_i;
		state_d.sda_s2 = state_q.sda_s1;
		state_d.sda_p = state_q.sda_s2;
		state_d.oe_s1 = oe_n_i;
		state_d.oe_s2 = state_q.oe_s1;
		state_d.rstn_s1 = reset_n_i;
		state_d.rstn_s2 = state_q.rstn_s1;

		scl_rise = state_q.scl_s2 & ~state_q.scl_p;
		scl_fall = ~state_q.scl_s2 & state_q.scl_p;
		start = state_q.scl_s2 & state_q.scl_p & state_q.sda_p & ~state_q.sda_s2;
		stop = state_q.scl_s2 & state_q.scl_p & ~state_q.sda_p & state_q.sda_s2;
		busy = (state_q.rec_cnt != '0) | state_q.pin_held;

		// Individual waveform: 40 MHz / 5 = 8 MHz steps, 256 steps per 31.25 kHz period
		step = (state_q.pre == `PWM_PRE_MAX);
		state_d.pre = step ? 3'h0 : state_q.pre + 3'h1;
		if (step)
		begin
			state_d.pcnt = state_q.pcnt + 8'h01;
		end
		wrap = step & (state_q.pcnt == 8'hFF);

		// Group waveform: one step per individual period gives 122 Hz when dimming;
		// blinking stretches each step by 8 * (freq + 1) periods, about 15 Hz to 16.8 s
		glim = {state_q.gfreq, `BLINK_SUB};
		if (wrap)
		begin
			if (state_q.blink_sel)
			begin
				if (state_q.gpre >= glim)
				begin
					state_d.gpre = 11'h000;
					state_d.gcnt = state_q.gcnt + 8'h01;
				end
				else
				begin
					state_d.gpre = state_q.gpre + 11'h001;
				end
			end
			else
			begin
				state_d.gpre = 11'h000;
				state_d.gcnt = state_q.gcnt + 8'h01;
			end
		end

		grp = state_q.gcnt < state_q.gduty;
		for (int i = 0; i < `NUM_LED; i++)
		begin
			ind = state_q.pcnt < state_q.bright[i];
			case (state_q.drive[2*i+:2])
				`MODE_OFF: state_d.led[i] = 1'b0;
				`MODE_ON: state_d.led[i] = 1'b1;
				`MODE_IND: state_d.led[i] = ind;
				`MODE_IND_GRP: state_d.led[i] = ind & grp;
				default: state_d.led[i] = 1'b0;
			endcase
		end

		// The enable pin only gates the drivers; settings stay untouched
		state_d.led_oe = {`NUM_LED{~state_q.oe_s2}};

		// Wishbone: answer one cycle after the request, drop ack the cycle after
		req = cyc_i & stb_i & ~state_q.wb_ack;
		state_d.wb_ack = req;
		if (req)
		begin
			case (adr_i)
				`ADR_CTRL: rd[`CTRL_BLINK_BIT] = state_q.blink_sel;
				`ADR_DRIVE: rd = state_q.drive;
				`ADR_GDUTY: rd[7:0] = state_q.gduty;
				`ADR_GFREQ: rd[7:0] = state_q.gfreq;
				`ADR_STATUS:
				begin
					rd[`STAT_READY_BIT] = state_q.ready;
					rd[`STAT_OE_BIT] = state_q.oe_s2;
					rd[`STAT_PINRST_BIT] = state_q.pin_held;
					rd[`STAT_I2C_BIT] = (state_q.i2c != I2C_IDLE);
				end
				default:
				begin
					if (is_bright(adr_i))
					begin
						rd[7:0] = state_q.bright[adr_i[5:2]];
					end
				end
			endcase
			state_d.wb_dat = rd;
			if (we_i)
			begin
				case (adr_i)
					`ADR_CTRL:
					begin
						wr = merge(rd, dat_i, sel_i);
						state_d.blink_sel = wr[`CTRL_BLINK_BIT];
					end
					`ADR_DRIVE: state_d.drive = merge(state_q.drive, dat_i, sel_i);
					`ADR_GDUTY:
					begin
						wr = merge(rd, dat_i, sel_i);
						state_d.gduty = wr[7:0];
					end
					`ADR_GFREQ:
					begin
						wr = merge(rd, dat_i, sel_i);
						state_d.gfreq = wr[7:0];
					end
					default:
					begin
						if (is_bright(adr_i))
						begin
							wr = merge(rd, dat_i, sel_i);
							state_d.bright[adr_i[5:2]] = wr[7:0];
						end
					end
				endcase
			end
		end

		// Serial slave: only the general call reset is recognised here
		state_d.sda_out = 1'b0;
		if (busy)
		begin
			state_d.i2c = I2C_IDLE;
			state_d.sda_oe = 1'b0;
			state_d.armed = 1'b0;
		end
		else if (start)
		begin
			state_d.i2c = I2C_ADDR;
			state_d.bitcnt = 4'h0;
			state_d.armed = 1'b0;
			state_d.first = 1'b1;
			state_d.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			state_d.i2c = I2C_IDLE;
			state_d.sda_oe = 1'b0;
			state_d.armed = 1'b0;
			if (state_q.armed)
			begin
				state_d = clear_cfg(state_d);
				state_d.rec_cnt = `REC_W'(SW_REC_CYC);
			end
		end
		else
		begin
			case (state_q.i2c)
				I2C_ADDR, I2C_DATA:
				begin
					if (scl_rise && state_q.bitcnt < 4'h8)
					begin
						state_d.shreg = {state_q.shreg[6:0], state_q.sda_s2};
						state_d.bitcnt = state_q.bitcnt + 4'h1;
					end
					else if (scl_fall && state_q.bitcnt == 4'h8)
					begin
						if (state_q.i2c == I2C_ADDR)
						begin
							if (state_q.shreg == `GC_WRITE_BYTE)
							begin
								state_d.sda_oe = 1'b1;
								state_d.i2c = I2C_ACK;
							end
							else
							begin
								state_d.i2c = I2C_IGNORE;
							end
						end
						else if (state_q.first && state_q.shreg == `BUS_SOFTWARE_RESET_CALL_BYTE)
						begin
							state_d.sda_oe = 1'b1;
							state_d.armed = 1'b1;
							state_d.first = 1'b0;
							state_d.i2c = I2C_ACK;
						end
						else
						begin
							// Any extra or wrong byte voids the call
							state_d.armed = 1'b0;
							state_d.i2c = I2C_IGNORE;
						end
					end
				end
				I2C_ACK:
				begin
					// Held low through the ninth pulse, released on its falling edge
					if (scl_fall)
					begin
						state_d.sda_oe = 1'b0;
						state_d.bitcnt = 4'h0;
						state_d.i2c = I2C_DATA;
					end
				end
				I2C_IGNORE: state_d.sda_oe = 1'b0;
				default: state_d.i2c = I2C_IDLE;
			endcase
		end

		// Reset pin: a low shorter than the minimum pulse is treated as a glitch
		if (!state_q.rstn_s2)
		begin
			if (state_q.pin_cnt != `PIN_CNT_W'(`PIN_RST_MIN_CYC))
			begin
				state_d.pin_cnt = state_q.pin_cnt + `PIN_CNT_W'(1);
			end
			else
			begin
				state_d.pin_held = 1'b1;
			end
		end
		else
		begin
			state_d.pin_cnt = '0;
			state_d.pin_held = 1'b0;
			if (state_q.pin_held)
			begin
				state_d.rec_cnt = `REC_W'(PIN_REC_CYC);
			end
		end
		if (state_q.pin_held)
		begin
			state_d = clear_cfg(state_d);
		end

		if (state_q.rec_cnt != '0 && state_d.rec_cnt == state_q.rec_cnt)
		begin
			state_d.rec_cnt = state_q.rec_cnt - `REC_W'(1);
		end
		state_d.ready = (state_d.rec_cnt == '0) & ~state_d.pin_held;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// Power-on: everything zero except the synchronisers, which idle high, then the wake-up wait
			state_q <= '0;
			state_q.scl_s1 <= 1'b1;
			state_q.scl_s2 <= 1'b1;
			state_q.scl_p <= 1'b1;
			state_q.sda_s1 <= 1'b1;
			state_q.sda_s2 <= 1'b1;
			state_q.sda_p <= 1'b1;
			state_q.oe_s1 <= 1'b1;
			state_q.oe_s2 <= 1'b1;
			state_q.rstn_s1 <= 1'b1;
			state_q.rstn_s2 <= 1'b1;
			state_q.rec_cnt <= `REC_W'(POR_WAKE_CYC);
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign dat_o = state_q.wb_dat;
	assign ack_o = state_q.wb_ack;
	assign sda_o = state_q.sda_out;
	assign sda_oe_o = state_q.sda_oe;
	assign led_o = state_q.led;
	assign led_oe_o = state_q.led_oe;
	assign ready_o = state_q.ready;
endmodule

/* File: pkg/led_ctrl_map.svh */
// Constants of the LED driver reset, enable and bus reset block
// Behaviour
// - Enable input low enables all outputs
// - Enable input high floats all sixteen outputs
// - Power-on clears registers and serial state
// - Supply return re-resets, ready within 2 ms
// - Operational within 1.5 ms after pin release
// - Ready within 1 ms after bus reset
// - Acknowledge general call address with write
// - General call with read left unacknowledged
// - Acknowledge only 06h as first byte
// - Further bytes after reset byte unacknowledged
// - STOP after valid call restores defaults
// - Malformed call performs no reset
// - Per-channel 31.25 kHz 8-bit brightness waveform
// - Group dimming overlays 122 Hz 8-bit waveform
// - Group blinking period 15 Hz to 16.8 s
// - Data change during clock high is control
// - START and STOP detected while clock high
// - Hold data low through ninth clock pulse
// - Transmitter releases data line after master NACK; this block never transmits and only drives the acknowledge bit
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

`define NUM_LED 16
`define CLK_PERIOD_NS 25
`define POR_WAKE_NS 2000000
`define POR_WAKE_CYC (`POR_WAKE_NS / `CLK_PERIOD_NS)
`define PIN_RST_MIN_NS 2500
`define PIN_RST_MIN_CYC ((`PIN_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_REC_NS 1500000
`define PIN_REC_CYC (`PIN_REC_NS / `CLK_PERIOD_NS)
`define SW_REC_NS 1000000
`define SW_REC_CYC (`SW_REC_NS / `CLK_PERIOD_NS)
`define REC_W 17
`define PIN_CNT_W 7
`define PWM_PRE_MAX 3'h4
`define BLINK_SUB 3'h7
`define GC_WRITE_BYTE 8'h00
`define BUS_SOFTWARE_RESET_CALL_BYTE 8'h06
`define MODE_OFF 2'h0
`define MODE_ON 2'h1
`define MODE_IND 2'h2
`define MODE_IND_GRP 2'h3
`define ADR_CTRL 8'h00
`define ADR_DRIVE 8'h04
`define ADR_GDUTY 8'h08
`define ADR_GFREQ 8'h0C
`define ADR_STATUS 8'h10
`define ADR_BRIGHT 8'h40
`define CTRL_BLINK_BIT 0
`define STAT_READY_BIT 0
`define STAT_OE_BIT 1
`define STAT_PINRST_BIT 2
`define STAT_I2C_BIT 3

`endif

/* File: pkg/led_ctrl_pkg.sv */
// Types of the LED driver reset, enable and bus reset block
`include "led_ctrl_map.svh"
package led_ctrl_pkg;
	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_DATA, I2C_ACK, I2C_IGNORE} i2c_state_t;
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic oe_s1;
		logic oe_s2;
		logic rstn_s1;
		logic rstn_s2;
		i2c_state_t i2c;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic first;
		logic armed;
		logic sda_oe;
		logic sda_out;
		logic [`PIN_CNT_W-1:0] pin_cnt;
		logic pin_held;
		logic [`REC_W-1:0] rec_cnt;
		logic blink_sel;
		logic [2*`NUM_LED-1:0] drive;
		logic [7:0] gduty;
		logic [7:0] gfreq;
		logic [`NUM_LED-1:0][7:0] bright;
		logic [2:0] pre;
		logic [7:0] pcnt;
		logic [10:0] gpre;
		logic [7:0] gcnt;
		logic [`NUM_LED-1:0] led;
		logic [`NUM_LED-1:0] led_oe;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic ready;
	} st_t;
endpackage

/* File: testbench/led_ctrl_checker.sv */
// Port assertions of the LED reset and enable block
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_ctrl_checker #(
	parameter int POR_WAKE_CYC = 50
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic oe_n_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [`NUM_LED-1:0] led_o,
	input wire logic [`NUM_LED-1:0] led_oe_o,
	input wire logic ready_o
);
	logic [15:0] up_q, low_q;
	// A held reset pin restarts the wait count, so only the recovery itself is bounded
	always_ff @(posedge clk_i)
	begin
		up_q <= rst_i ? 16'h0 : up_q + {15'h0, up_q != 16'hFFFF};
		low_q <= (rst_i || ready_o || !reset_n_i) ? 16'h0 : low_q + 16'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_pulse:
		assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not one pulse");
	a_ack_needs_req:
		assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	a_oe_follows_pin:
		assert property ($stable(oe_n_i) [*5] |-> led_oe_o == {`NUM_LED{!oe_n_i}})
		else $error("enables do not follow pin");
	a_oe_all_same:
		assert property (led_oe_o == '0 || led_oe_o == '1)
		else $error("enables split");
	a_ack_scl_low:
		assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data moved with clock high");
	a_sda_pull_low:
		assert property (sda_oe_o |-> !sda_o && ready_o)
		else $error("bad data drive");
	a_por_wait:
		assert property (up_q < POR_WAKE_CYC |-> !ready_o)
		else $error("ready too early");
	a_ready_bound:
		assert property (low_q <= POR_WAKE_CYC + 8)
		else $error("ready too late");
	a_por_clears:
		assert property ($fell(rst_i) |-> led_o == '0 && !sda_oe_o && !ack_o)
		else $error("state not cleared");
	c_ack: cover property (ack_o);
	c_dev_ack: cover property ($rose(sda_oe_o));
	c_not_ready: cover property ($fell(ready_o));
endmodule

/* File: testbench/i2c_master_model.sv */
// Behavioural bus master driving the serial clock and data lines
`timescale 1ns/1ps
module i2c_master_model (
	// Clock and wire data level
	input wire logic clk_i,
	input wire logic sda_i,
	// Driven lines, 1 releases to the pull-up
	output logic scl_o,
	output logic sda_o
);
	logic r;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic quarter();
		repeat (4) @(posedge clk_i);
	endtask
	// Leading wait keeps data from moving on the edge where the clock falls
	task automatic start_c();
		quarter();
		sda_o <= 1'b1;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_o <= 1'b0;
		quarter();
		scl_o <= 1'b0;
	endtask
	task automatic stop_c();
		quarter();
		sda_o <= 1'b0;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_o <= 1'b1;
		quarter();
	endtask
	task automatic bit_x(input logic b, output logic s);
		@(posedge clk_i);
		sda_o <= b;
		repeat (3) @(posedge clk_i);
		scl_o <= 1'b1;
		quarter();
		s = sda_i;
		scl_o <= 1'b0;
	endtask
	// MSB first, then a released ninth bit; a is high when the device pulled low
	task automatic xfer(input logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		a = !r;
	endtask
endmodule

/* File: testbench/led_driver_reset_enable_ctrl_test.sv */
// Self-checking bench of the LED reset and enable block
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_driver_reset_enable_ctrl_test;
	localparam int POR = 50;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, oe_n_i = 0, reset_n_i = 1;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0;
	logic [31:0] dat_o, rd;
	logic ack_o, sda_o, sda_oe_o, ready_o, scl_i, sda_m, ack;
	logic [`NUM_LED-1:0] led_o, led_oe_o;
	wire sda_i = sda_m & !(sda_oe_o & !sda_o);
	int bad_count = 0;
	int tests_run = 0;
	int seed = 23332;
	int n, v;
	int mdl[int];
	initial forever #12.5 clk_i = !clk_i;
	led_reset_enable_ctrl #(.POR_WAKE_CYC(POR), .PIN_REC_CYC(40), .SW_REC_CYC(30))
		led_reset_enable_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .oe_n_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
		.led_o, .led_oe_o, .ready_o);
	i2c_master_model i2c_master_model_inst (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i),
		.sda_o(sda_m));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	function automatic int msk(input int a);
		if (a == 0)
			return 1;
		if (a == 4)
			return -1;
		return (a == 8 || a == 12 || a >= 64 && a < 128) ? 255 : 0;
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
		n = 0;
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
		chk(ack_o, 1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		if (w)
			mdl[a] = d & msk(a);
	endtask
	task automatic rdc(input logic [7:0] a);
		wb(0, a, 0);
		chk(rd, mdl.exists(a) ? mdl[a] : 0);
	endtask
	task automatic pwm(input int e);
		repeat (8) @(posedge clk_i);
		n = 0;
		repeat (1280) @(posedge clk_i) n += led_o[0];
		chk(n, e);
	endtask
	task automatic gc(input logic [7:0] q[$], input logic [3:0] e);
		i2c_master_model_inst.start_c();
		foreach (q[i])
		begin
			i2c_master_model_inst.xfer(q[i], ack);
			chk(ack, e[i]);
		end
		i2c_master_model_inst.stop_c();
	endtask
	task automatic wait_ready();
		n = 0;
		while (ready_o !== 1'b1 && n++ < 500)
			@(posedge clk_i);
		chk(ready_o, 1);
	endtask
	task automatic finish_test();
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#1000000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		rdc(8'h04);
		rdc(8'h40);
		chk(ready_o, 0);
		wait_ready();
		for (int i = 0; i < 16; i++)
			wb(1, 8'(64 + 4 * i), $random(seed));
		wb(1, 8'h24, $random(seed));
		wb(1, 8'h04, 32'h5555_5555);
		repeat (8) @(posedge clk_i);
		chk(led_o, 16'hFFFF);
		// One gating pulse with every channel fully on, no group mode in use
		oe_n_i <= 1;
		repeat (8) @(posedge clk_i);
		chk(led_oe_o, 16'h0);
		oe_n_i <= 0;
		repeat (8) @(posedge clk_i);
		chk(led_oe_o, 16'hFFFF);
		chk(led_o, 16'hFFFF);
		// Group select only after the gating pulse, so the pulse never meets internal blinking
		wb(1, 8'h00, $random(seed));
		for (int a = 0; a < 128; a += 4)
			if (a != 16)
				rdc(8'(a));
		v = $random(seed) & 255;
		wb(1, 8'h40, v);
		wb(1, 8'h04, 32'h2);
		pwm(v * 5);
		wb(1, 8'h04, 32'h3);
		pwm(0);
		// Full group duty lets the individual waveform through again
		wb(1, 8'h08, 32'h0000_00FF);
		pwm(v * 5);
		gc({8'h01}, 4'h0);
		gc({8'h00, 8'h07}, 4'h1);
		gc({8'h00, 8'h06, 8'h06}, 4'h3);
		rdc(8'h04);
		gc({8'h00, 8'h06}, 4'h3);
		chk(ready_o, 0);
		// Outputs are one register behind the cleared drive modes
		@(posedge clk_i);
		chk(led_o, 16'h0);
		mdl.delete();
		rdc(8'h04);
		wait_ready();
		wb(1, 8'h04, 32'h5555_5555);
		reset_n_i <= 0;
		repeat (60) @(posedge clk_i);
		reset_n_i <= 1;
		rdc(8'h04);
		reset_n_i <= 0;
		repeat (120) @(posedge clk_i);
		chk(ready_o, 0);
		wb(0, 8'h10, 0);
		chk(rd, 32'h0000_0004);
		reset_n_i <= 1;
		mdl.delete();
		rdc(8'h04);
		wait_ready();
		wb(0, 8'h10, 0);
		chk(rd, 32'h0000_0001);
		finish_test();
	end
endmodule
bind led_reset_enable_ctrl led_ctrl_checker #(.POR_WAKE_CYC(POR_WAKE_CYC)) led_ctrl_checker_inst (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.oe_n_i(oe_n_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .led_o(led_o), .led_oe_o(led_oe_o), .ready_o(ready_o));
